// ### verilog/tape_row_cfg.svh
// Constants for the tape row strobe gating block.
// Assumes inclusion by bare name from the package and design files.
`ifndef TAPE_ROW_CFG_SVH
`define TAPE_ROW_CFG_SVH

`define DATA_CHANNELS   8
`define SYNC_STAGES     2
`define HOLE_VALUE      1'b1
`define NO_HOLE_VALUE   1'b0
`define STROBE_N_IDLE   1'b1

`endif

// ### verilog/tape_row_pkg.sv
// Types for the tape row strobe gating block.
// Assumes the configuration header is on the include path.
`include "tape_row_cfg.svh"

package tape_row_pkg;

    typedef logic [`DATA_CHANNELS-1:0] row_word_t;

    typedef struct packed {
        logic      sprocket;
        row_word_t data;
    } hole_sense_t;

    typedef struct packed {
        logic stopRequest;
        logic startRequest;
    } motion_cmd_t;

    typedef enum logic {
        RUN_FREE,
        HELD
    } hold_state_t;

endpackage

// ### verilog/hole_sync.sv
// Two-stage synchroniser for a bundle of asynchronous level inputs.
// Assumes a free-running clock; first stage feeds only the second.
`timescale 1ns/100ps

module hole_sync #(
    parameter int WIDTH = 11
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Levels
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    always_comb begin
        nxt_meta = rst_n ? asyncIn : '0;
        nxt_sync = rst_n ? meta_ff : '0;
    end

    always_ff @(posedge clk) begin
        meta_ff <= nxt_meta;
        sync_ff <= nxt_sync;
    end

    assign syncOut = sync_ff;

endmodule // hole_sync

// ### verilog/tape_row_strobe_gating.sv
// Sprocket-gated row output for a perforated-tape reader.
// Assumes hole sensors and stop/start requests are levels, sampled on clk.
//
// Functional notes
// - A sensed hole reads as one on its output, no hole as zero.
// - Sprocket hole yields a clean sprocket-present level to strobe generation.
// - Internal active-low strobe is zero exactly while sprocket hole sensed or stop-hold is held.
// - External strobe is complement of internal strobe, high during hole.
// - Eight parallel data outputs, one per tape data track.
// - Gated mode without stop-hold: data output asserted only when its hole and strobe coincide.
// - One common strobe gates all eight channels, same start and end.
// - Ungated configuration passes data sensors straight through, not gated by the strobe, which is still driven.
// - Stop-hold mode ORs stop request into sprocket path, forcing strobe.
// - Forced strobe persists until a start request, then releases.
// - Stop-hold in gated mode: asserted data feeds back, holding itself while strobe zero.
// - Stop-hold in gated mode: data stays latched until start, then all released.
// - Gated mode combines each channel's hole with the internal strobe.
`timescale 1ns/100ps
`include "tape_row_cfg.svh"

module tape_row_strobe_gating
    import tape_row_pkg::*;
#(
    parameter int CHANNELS = `DATA_CHANNELS
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Hole sensors
    input  wire logic                sprocketHole,
    input  wire logic [CHANNELS-1:0] dataHole,
    // Motion control requests
    input  wire logic                stopRequest,
    input  wire logic                startRequest,
    // Configuration straps
    input  wire logic                gatedMode,
    input  wire logic                stop_hold_option,
    // Row outputs
    output logic                     row_strobe,
    output logic                     row_strobe_n,
    output logic      [CHANNELS-1:0] rowData
);

    localparam int SYNC_W = CHANNELS + 3;

    logic [SYNC_W-1:0]   syncIn;
    logic [SYNC_W-1:0]   syncOut;
    logic                holeSprocket;
    logic [CHANNELS-1:0] holeData;
    motion_cmd_t         cmd;

    hold_state_t         hold_ff;
    hold_state_t         nxt_hold;
    logic                strobeN_ff;
    logic                nxt_strobeN;
    logic                strobe_ff;
    logic                nxt_strobe;
    logic [CHANNELS-1:0] data_ff;
    logic [CHANNELS-1:0] nxt_data;
    logic                strobeNNow;

    assign syncIn = {sprocketHole, stopRequest, startRequest, dataHole};

    hole_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .asyncIn (syncIn),
        .syncOut (syncOut)
    );

    assign holeSprocket     = syncOut[SYNC_W-1];
    assign cmd.stopRequest  = syncOut[SYNC_W-2];
    assign cmd.startRequest = syncOut[SYNC_W-3];
    assign holeData         = syncOut[CHANNELS-1:0];

    // Stop-hold state: a start in the same cycle as a stop wins release.
    always_comb begin
        nxt_hold = hold_ff;
        case (hold_ff)
            RUN_FREE: begin
                if (stop_hold_option && cmd.stopRequest &&
                    !cmd.startRequest) begin
                    nxt_hold = HELD;
                end
            end
            HELD: begin
                if (cmd.startRequest || !stop_hold_option) begin
                    nxt_hold = RUN_FREE;
                end
            end
            default: nxt_hold = RUN_FREE;
        endcase
        if (!rst_n) begin
            nxt_hold = RUN_FREE;
        end
    end

    always_ff @(posedge clk) begin
        hold_ff <= nxt_hold;
    end

    always_comb begin
        strobeNNow  = !(holeSprocket || nxt_hold == HELD);
        nxt_strobeN = rst_n ? strobeNNow : `STROBE_N_IDLE;
        nxt_strobe  = !nxt_strobeN;
    end

    always_ff @(posedge clk) begin
        strobeN_ff <= nxt_strobeN;
        strobe_ff  <= nxt_strobe;
    end

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            always_comb begin
                if (!rst_n) begin
                    nxt_data[ch] = `NO_HOLE_VALUE;
                end else if (!gatedMode) begin
                    nxt_data[ch] = holeData[ch];
                end else if (stop_hold_option) begin
                    nxt_data[ch] = (holeData[ch] || data_ff[ch]) &&
                                   !strobeNNow;
                end else begin
                    nxt_data[ch] = holeData[ch] && !strobeNNow;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        data_ff <= nxt_data;
    end

    assign rowData      = data_ff;
    assign row_strobe_n = strobeN_ff;
    assign row_strobe   = strobe_ff;

endmodule // tape_row_strobe_gating

// ### verification/tape_row_chk.sv
// Checker bound into the tape row strobe gating block.
// Assumes sensor and request inputs reach the outputs three clock edges after they change.
`timescale 1ns/100ps
module tape_row_chk #(parameter int CHANNELS = 8) (
    // Clock and reset
    input wire logic                clk,
    input wire logic                rst_n,
    // Sensors, requests and straps
    input wire logic                sprocketHole,
    input wire logic [CHANNELS-1:0] dataHole,
    input wire logic                stopRequest,
    input wire logic                startRequest,
    input wire logic                gatedMode,
    input wire logic                stop_hold_option,
    // Row outputs
    input wire logic                row_strobe,
    input wire logic                row_strobe_n,
    input wire logic [CHANNELS-1:0] rowData
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    strobe_pair_a: assert property (row_strobe != row_strobe_n)
        else $error("strobe pair");
    // The straps act on the edge that registers the outputs, one edge back.
    strobe_time_a: assert property (!$past(stop_hold_option)
        |-> row_strobe == $past(sprocketHole,3)) else $error("strobe");
    gate_data_a: assert property ($past(gatedMode)
        && !$past(stop_hold_option)
        |-> rowData == ($past(sprocketHole,3) ? $past(dataHole,3) : '0))
        else $error("gated data");
    pass_data_a: assert property (!$past(gatedMode)
        |-> rowData == $past(dataHole,3)) else $error("ungated data");
    stop_force_a: assert property ($past(stopRequest,3)
        && !$past(startRequest,3) && $past(stop_hold_option)
        |-> row_strobe) else $error("stop");
    hold_keep_a: assert property (stop_hold_option && row_strobe
        && !$past(sprocketHole,3) && !$past(startRequest,2) |=> row_strobe)
        else $error("hold lost");
    hold_release_a: assert property ($past(startRequest,3)
        && !$past(sprocketHole,3) && stop_hold_option
        |-> !row_strobe && (!gatedMode || rowData == '0))
        else $error("release");
    data_hold_a: assert property (stop_hold_option && gatedMode
        && row_strobe && !$past(sprocketHole,3) && !$past(startRequest,2)
        |=> (rowData & $past(rowData)) == $past(rowData)) else $error("hold");
    row_c: cover property (row_strobe && rowData != '0);
    hold_c: cover property (stop_hold_option && row_strobe);
    pass_c: cover property (!gatedMode && rowData != '0);
    order_c: cover property (stop_hold_option && !gatedMode && row_strobe);
endmodule // tape_row_chk
bind tape_row_strobe_gating tape_row_chk #(.CHANNELS(CHANNELS)) chk (.*);

// ### verification/row_consumer.sv
// Model of the equipment that takes a row while the strobe is high.
// Assumes the row outputs settle on the rising edge of clk.
`timescale 1ns/100ps
module row_consumer (
    // Clock and row
    input  wire logic       clk,
    input  wire logic       row_strobe,
    input  wire logic [7:0] rowData,
    // Last row taken
    output logic      [7:0] lastRow
);
    always @(posedge clk) begin
        if (row_strobe) begin
            lastRow <= rowData;
        end
    end
endmodule // row_consumer

// ### verification/tb.sv
// Self-checking bench for the tape row strobe gating block.
// Assumes the block, its checker and the row consumer are compiled first.
`timescale 1ns/100ps
module tb;
    logic       clk = 0, rst_n = 0, sprocketHole = 0, gatedMode = 1;
    logic       stopRequest = 0, startRequest = 0, stop_hold_option = 0;
    logic [7:0] dataHole = '0, rowData, lastRow;
    logic       row_strobe, row_strobe_n;
    int         failures = 0, checked = 0;
    tape_row_strobe_gating DUT (.*);
    row_consumer partner (.clk(clk), .row_strobe(row_strobe),
        .rowData(rowData), .lastRow(lastRow));
    always #50 clk = ~clk;
    task automatic ck(string n, logic [9:0] s, logic [9:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Waits out the three-edge latency, then compares the outputs.
    task automatic look(string n, logic [9:0] e);
        repeat (3) @(posedge clk);
        @(negedge clk);
        ck(n, {row_strobe, row_strobe_n, rowData}, e);
        @(posedge clk);
    endtask
    task automatic t_gated;
        dataHole <= 8'h5a;
        look("no sprocket", 10'h100);
        sprocketHole <= 1;
        look("gated row", 10'h25a);
        {sprocketHole, dataHole, stopRequest} <= 10'h001;
        look("stop ignored", 10'h100);
        stopRequest <= 0;
        ck("consumer", {2'h0, lastRow}, 10'h05a);
    endtask
    task automatic t_pass;
        gatedMode <= 0;
        dataHole <= 8'ha5;
        look("ungated", 10'h1a5);
        dataHole <= 8'h00;
        look("ungated clear", 10'h100);
    endtask
    task automatic t_hold;
        {gatedMode, stop_hold_option, sprocketHole} <= 3'h7;
        dataHole <= 8'h3c;
        stopRequest <= 1;
        look("stop row", 10'h23c);
        {stopRequest, sprocketHole, dataHole} <= 10'h000;
        look("held row", 10'h23c);
        startRequest <= 1;
        look("released", 10'h100);
        startRequest <= 0;
    endtask
    // Start beside stop, a hold with ungated data, then the strap cleared.
    task automatic t_order;
        {stopRequest, startRequest} <= 2'h3;
        look("start wins", 10'h100);
        {gatedMode, stopRequest, startRequest} <= 3'h2;
        dataHole <= 8'h81;
        look("ungated hold", 10'h281);
        {stop_hold_option, stopRequest} <= 2'h0;
        dataHole <= 8'h18;
        look("strap release", 10'h118);
    endtask
    task automatic give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        ck("reset", {row_strobe, row_strobe_n, rowData}, 10'h100);
        @(posedge clk);
        rst_n <= 1;
        t_gated();
        t_pass();
        t_hold();
        t_order();
        give_verdict();
    end
    initial begin
        repeat (500) @(posedge clk);
        failures++;
        give_verdict();
    end
endmodule // tb
